// [asc_regs.svh]
// Register map and timing constants of the serial controller.
// Assumes a 32-bit AHB-Lite slave with one register per word.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// Byte offsets
`define ASC_OFS_C1     8'h00
`define ASC_OFS_C2     8'h04
`define ASC_OFS_C3     8'h08
`define ASC_OFS_STAT   8'h0C
`define ASC_OFS_DATA   8'h10
`define ASC_OFS_BAUD   8'h14
// Control one fields
`define ASC_C1_LOOP    7
`define ASC_C1_ON      6
`define ASC_C1_INV     5
`define ASC_C1_NINE    4
`define ASC_C1_WAKE    3
`define ASC_C1_IDLE_COUNT_AFTER_STOP    2
`define ASC_C1_PEN     1
`define ASC_C1_ODD     0
// Control two fields
`define ASC_C2_TIE     7
`define ASC_C2_TX_DONE_IRQ_EN    6
`define ASC_C2_RIE     5
`define ASC_C2_IDLE_IRQ_EN    4
`define ASC_C2_TXON    3
`define ASC_C2_RXON    2
`define ASC_C2_STBY    1
`define ASC_C2_SBK     0
// Control three fields
`define ASC_C3_R9      7
`define ASC_C3_T9      6
// Reset values
`define ASC_RST_C1     8'h00
`define ASC_RST_C2     8'h00
`define ASC_RST_BAUD   8'h0F
// Oversampling: last and middle sample of a bit
`define ASC_RT_LAST    4'hF
`define ASC_RT_MID     4'h7
// Frame lengths in bits
`define ASC_LEN_SHORT  4'hA
`define ASC_LEN_LONG   4'hB
`endif

// [asc_pkg.sv]
// Types shared by the serial controller.
// Assumes nothing beyond a SystemVerilog compiler.
package asc_pkg;
    typedef enum logic [1:0] {
        ASC_RX_IDLE  = 2'b00,
        ASC_RX_START = 2'b01,
        ASC_RX_DATA  = 2'b10
    } asc_rx_st_t;
endpackage : asc_pkg

// [asc_ctrl.sv]
// Asynchronous serial transceiver with control registers on AHB-Lite.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
// Operation
// - Enabled module always drives the transmit pin as output.
// - Enabled module always treats the receive pin as input.
// - Loopback feeds transmitter into receiver; software enables both ends.
// - Module enable runs logic; disabling sets empty, done, blocks tx requests.
// - Inversion flips every transmitted level including idle and break.
// - Length bit picks nine-bit or eight-bit characters.
// - Wakeup bit picks address-mark wakeup or idle-line wakeup.
// - Idle count starts after stop bit or after start bit.
// - Parity enable generates and checks parity in the top bit.
// - Parity select picks odd or even for both directions.
// - Frames are ten or eleven bits with one start, one stop.
// - Separate enables gate empty, done, full and idle requests.
// - Enabling transmitter first sends a preamble of all ones.
// - Disabling transmitter finishes current character, then line idles high.
// - Disable then enable during a character queues one idle character.
// - Receiver enable runs receiver; disabling keeps receiver flags.
// - Standby blocks rx requests; wakeup event clears standby.
// - Break toggle sends one break then a one; held breaks repeat.
// - Break pending before preamble replaces the preamble.
// - Received ninth bit captured with data, or copy of bit seven.
// - Transmit ninth bit loaded with data; reset leaves it alone.
// - Reset clears all bits of control one and control two.
// - Address mark ending standby also sets receive full.
// - Idle ending standby sets neither idle nor receive full.
`include "asc_regs.svh"
module asc_ctrl (
    input  wire logic        clk_i,             // 20 MHz clock
    input  wire logic        nrst_i,            // Sync reset, low
    input  wire logic        hsel_i,            // Slave select
    input  wire logic [31:0] haddr_i,           // Address
    input  wire logic [1:0]  htrans_i,          // Transfer type
    input  wire logic        hwrite_i,          // Write
    input  wire logic [2:0]  hsize_i,           // Size, word only
    input  wire logic [31:0] hwdata_i,          // Write data
    input  wire logic        hready_i,          // Bus ready
    output logic      [31:0] hrdata_o,          // Read data
    output logic             hreadyout_o,       // Slave ready
    output logic             hresp_o,           // Always OKAY
    input  wire logic        serial_in_pin_i,   // Receive pin level
    input  wire logic        in_pin_dir_bit_i,  // Port dir, rx pin
    input  wire logic        out_pin_dir_bit_i, // Port dir, tx pin
    input  wire logic        port_out_i,        // Port latch, tx pin
    output logic             serial_out_pin_o,  // Transmit pin level
    output logic             serial_out_oe_o,   // Transmit pin enable
    output logic             serial_in_oe_o,    // Rx pin port enable
    output logic             tx_irq_o,          // Transmitter request
    output logic             rx_irq_o           // Receiver request
);
    logic [7:0]  c1_r, c2_r, baud_r, bcnt_r, addr_r, rxd_r, txh_r;
    logic        wr_r, rx9_r, tx9_r, s1_r, s2_r;
    logic        tx_empty_r, tx_done_r, rx_full_r, idle_r;
    logic        ovr_r, fe_r, pe_r, arm_r, pre_r, brk_r;
    logic [3:0]  trt_r, tcnt_r, rrt_r, rbit_r, ones_r;
    logic [10:0] tsh_r;
    logic [9:0]  rsh_r, frm;
    asc_pkg::asc_rx_st_t rst_r;

    logic on, nine, acc, rd_acc, rd_dat, wr_dat, wr_c2, rt, tbit;
    logic [3:0] flen;
    logic tx_line, rx_in, ren, rsamp, rdone, mark, idle_hit, deliver;
    logic ld_brk, ld_one, ld_pre, ld_dat, tx_load;

    // Parity of a character, over seven or eight data bits
    function automatic logic asc_par(input logic [8:0] v,
                                     input logic n9, input logic odd);
        asc_par = (n9 ? ^v[7:0] : ^v[6:0]) ^ odd;
    endfunction : asc_par

    assign on   = c1_r[`ASC_C1_ON];
    assign nine = c1_r[`ASC_C1_NINE];
    assign flen = nine ? `ASC_LEN_LONG : `ASC_LEN_SHORT;

    // Bus decode, address phase for reads, data phase for writes
    assign acc    = hsel_i & hready_i & htrans_i[1];
    assign rd_acc = acc & ~hwrite_i;
    assign rd_dat = rd_acc & (haddr_i[7:0] == `ASC_OFS_DATA);
    assign wr_dat = wr_r & (addr_r == `ASC_OFS_DATA);
    assign wr_c2  = wr_r & (addr_r == `ASC_OFS_C2);

    // Address phase latch
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_r   <= 1'b0;
            addr_r <= 8'h00;
        end else if (hready_i) begin
            wr_r   <= acc & hwrite_i;
            addr_r <= haddr_i[7:0];
        end
    end

    // Read data and zero-wait answer
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (rd_acc) begin
                case (haddr_i[7:0])
                    `ASC_OFS_C1:   hrdata_o <= {24'h0, c1_r};
                    `ASC_OFS_C2:   hrdata_o <= {24'h0, c2_r};
                    `ASC_OFS_C3:   hrdata_o <= {24'h0, rx9_r, tx9_r, 6'h00};
                    `ASC_OFS_STAT: hrdata_o <= {24'h0, tx_empty_r, tx_done_r,
                                                rx_full_r, idle_r, ovr_r, 1'b0,
                                                fe_r, pe_r};
                    `ASC_OFS_DATA: hrdata_o <= {24'h0, rxd_r};
                    `ASC_OFS_BAUD: hrdata_o <= {24'h0, baud_r};
                    default:       hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control one and baud register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            c1_r   <= `ASC_RST_C1;
            baud_r <= `ASC_RST_BAUD;
        end else if (wr_r) begin
            if (addr_r == `ASC_OFS_C1)
                c1_r <= hwdata_i[7:0];
            if (addr_r == `ASC_OFS_BAUD)
                baud_r <= hwdata_i[7:0];
        end
    end

    // Control two; transmitter and receiver enables ignored while module off, standby auto-clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            c2_r <= `ASC_RST_C2;
        end else if (wr_c2) begin
            c2_r <= hwdata_i[7:0];
            if (!on) begin
                c2_r[`ASC_C2_TXON] <= c2_r[`ASC_C2_TXON];
                c2_r[`ASC_C2_RXON] <= c2_r[`ASC_C2_RXON];
            end
        end else if ((rdone & mark & c1_r[`ASC_C1_WAKE]) |
                     (idle_hit & ~c1_r[`ASC_C1_WAKE])) begin
            c2_r[`ASC_C2_STBY] <= 1'b0;
        end
    end

    // Transmit holding data and ninth bit, untouched by reset
    always_ff @(posedge clk_i) begin
        if (wr_dat)
            txh_r <= hwdata_i[7:0];
        if (wr_r && addr_r == `ASC_OFS_C3)
            tx9_r <= hwdata_i[`ASC_C3_T9];
    end

    // Oversampling divider, runs only while enabled
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !on || rt)
            bcnt_r <= 8'h00;
        else
            bcnt_r <= bcnt_r + 8'h01;
    end
    assign rt = on & (bcnt_r == baud_r);

    // Transmit bit timer
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !on)
            trt_r <= 4'h0;
        else if (rt)
            trt_r <= trt_r + 4'h1;
    end
    assign tbit = rt & (trt_r == `ASC_RT_LAST);

    // Next frame choice at a frame boundary
    assign tx_load = tbit & (tcnt_r <= 4'h1);
    assign ld_brk  = c2_r[`ASC_C2_TXON] & c2_r[`ASC_C2_SBK];
    assign ld_one  = ~ld_brk & brk_r;
    assign ld_pre  = ~ld_brk & ~ld_one & pre_r & c2_r[`ASC_C2_TXON];
    assign ld_dat  = ~ld_brk & ~ld_one & ~ld_pre & c2_r[`ASC_C2_TXON]
                   & ~tx_empty_r;

    // Transmit shifter
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !on) begin
            tsh_r  <= 11'h7FF;
            tcnt_r <= 4'h0;
            brk_r  <= 1'b0;
        end else if (tx_load) begin
            brk_r <= ld_brk;
            if (ld_brk) begin
                tsh_r  <= 11'h000;
                tcnt_r <= flen;
            end else if (ld_one) begin
                tsh_r  <= 11'h7FF;
                tcnt_r <= 4'h1;
            end else if (ld_pre) begin
                tsh_r  <= 11'h7FF;
                tcnt_r <= flen;
            end else if (ld_dat) begin
                tcnt_r <= flen;
                if (nine)
                    tsh_r <= {1'b1, c1_r[`ASC_C1_PEN] ?
                              asc_par({tx9_r, txh_r}, 1'b1, c1_r[`ASC_C1_ODD])
                              : tx9_r, txh_r, 1'b0};
                else
                    tsh_r <= {2'b11, c1_r[`ASC_C1_PEN] ?
                              asc_par({1'b0, txh_r}, 1'b0, c1_r[`ASC_C1_ODD])
                              : txh_r[7], txh_r[6:0], 1'b0};
            end else begin
                tcnt_r <= 4'h0;
            end
        end else if (tbit && tcnt_r != 4'h0) begin
            tsh_r  <= {1'b1, tsh_r[10:1]};
            tcnt_r <= tcnt_r - 4'h1;
        end
    end
    assign tx_line = (tcnt_r != 4'h0) ? tsh_r[0] : 1'b1;

    // Pending preamble: set by each enabling write, cancelled by break
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !on)
            pre_r <= 1'b0;
        else if (wr_c2 && hwdata_i[`ASC_C2_TXON] && !c2_r[`ASC_C2_TXON])
            pre_r <= 1'b1;
        else if (tx_load && (ld_pre || ld_brk))
            pre_r <= 1'b0;
    end

    // Transmit empty and done flags; disabling forces both
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_empty_r <= 1'b1;
            tx_done_r  <= 1'b1;
        end else begin
            if (!on || (tx_load && ld_dat))
                tx_empty_r <= 1'b1;
            else if (wr_dat)
                tx_empty_r <= 1'b0;
            tx_done_r <= ~on | (tx_empty_r & (tcnt_r == 4'h0) & ~pre_r
                                & ~ld_brk & ~brk_r);
        end
    end

    // Receive pin synchroniser
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= serial_in_pin_i;
            s2_r <= s1_r;
        end
    end
    assign rx_in = c1_r[`ASC_C1_LOOP] ? tx_line : s2_r;
    assign ren   = on & c2_r[`ASC_C2_RXON];

    // Receive state machine
    assign rsamp = rt & (rrt_r == `ASC_RT_LAST);
    assign rdone = rsamp & (rst_r == asc_pkg::ASC_RX_DATA)
                 & (rbit_r == flen - 4'h2);
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !ren) begin
            rst_r  <= asc_pkg::ASC_RX_IDLE;
            rrt_r  <= 4'h0;
            rbit_r <= 4'h0;
        end else if (rt) begin
            rrt_r <= rrt_r + 4'h1;
            case (rst_r)
                asc_pkg::ASC_RX_IDLE: begin
                    if (!rx_in) begin
                        rst_r <= asc_pkg::ASC_RX_START;
                        rrt_r <= 4'h0;
                    end
                end
                asc_pkg::ASC_RX_START: begin
                    if (rrt_r == `ASC_RT_MID) begin
                        rst_r  <= rx_in ? asc_pkg::ASC_RX_IDLE
                                        : asc_pkg::ASC_RX_DATA;
                        rrt_r  <= 4'h0;
                        rbit_r <= 4'h0;
                    end
                end
                asc_pkg::ASC_RX_DATA: begin
                    if (rsamp) begin
                        rsh_r[rbit_r] <= rx_in;
                        rbit_r        <= rbit_r + 4'h1;
                        if (rdone)
                            rst_r <= asc_pkg::ASC_RX_IDLE;
                    end
                end
                default: rst_r <= asc_pkg::ASC_RX_IDLE;
            endcase
        end
    end

    // Frame as completed by the stop sample
    always_comb begin
        frm = rsh_r;
        frm[rbit_r] = rx_in;
    end
    assign mark = nine ? frm[8] : frm[7];

    // Idle counter of consecutive ones
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !ren) begin
            ones_r <= 4'h0;
        end else if (rdone && c1_r[`ASC_C1_IDLE_COUNT_AFTER_STOP]) begin
            ones_r <= 4'h0;
        end else if (rsamp && rst_r != asc_pkg::ASC_RX_START) begin
            if (!rx_in)
                ones_r <= 4'h0;
            else if ((rst_r == asc_pkg::ASC_RX_IDLE || !c1_r[`ASC_C1_IDLE_COUNT_AFTER_STOP])
                     && ones_r != flen)
                ones_r <= ones_r + 4'h1;
        end
    end
    assign idle_hit = rsamp & rx_in & (ones_r == flen - 4'h1);

    // A frame reaches software unless standby discards it
    assign deliver = rdone & (~c2_r[`ASC_C2_STBY] |
                              (c1_r[`ASC_C1_WAKE] & mark));

    // Receive data and ninth bit, untouched by reset
    always_ff @(posedge clk_i) begin
        if (deliver && !rx_full_r) begin
            rxd_r <= frm[7:0];
            rx9_r <= nine ? frm[8] : frm[7];
        end
    end

    // Receive flags; set wins over the clearing data read
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_full_r <= 1'b0;
            idle_r    <= 1'b0;
            ovr_r     <= 1'b0;
            fe_r      <= 1'b0;
            pe_r      <= 1'b0;
            arm_r     <= 1'b0;
        end else begin
            if (deliver && !rx_full_r) begin
                rx_full_r <= 1'b1;
                fe_r      <= ~frm[flen - 4'h2];
                pe_r      <= c1_r[`ASC_C1_PEN] &
                             (asc_par({frm[8], frm[7:0]}, nine,
                                      c1_r[`ASC_C1_ODD]) != mark);
            end else if (rd_dat) begin
                rx_full_r <= 1'b0;
                fe_r      <= 1'b0;
                pe_r      <= 1'b0;
            end
            if (deliver && rx_full_r)
                ovr_r <= 1'b1;
            else if (rd_dat)
                ovr_r <= 1'b0;
            if (idle_hit && arm_r && !c2_r[`ASC_C2_STBY])
                idle_r <= 1'b1;
            else if (rd_dat)
                idle_r <= 1'b0;
            if (deliver)
                arm_r <= 1'b1;
            else if (idle_hit && !c2_r[`ASC_C2_STBY])
                arm_r <= 1'b0;
        end
    end

    // Pin ownership and interrupt requests
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            serial_out_pin_o <= 1'b1;
            serial_out_oe_o  <= 1'b0;
            serial_in_oe_o   <= 1'b0;
            tx_irq_o         <= 1'b0;
            rx_irq_o         <= 1'b0;
        end else begin
            serial_out_pin_o <= on ? tx_line ^ c1_r[`ASC_C1_INV]
                                   : port_out_i;
            serial_out_oe_o  <= on | out_pin_dir_bit_i;
            serial_in_oe_o   <= ~on & in_pin_dir_bit_i;
            tx_irq_o <= on & ((c2_r[`ASC_C2_TIE] & tx_empty_r) |
                              (c2_r[`ASC_C2_TX_DONE_IRQ_EN] & tx_done_r));
            rx_irq_o <= ~c2_r[`ASC_C2_STBY] &
                        ((c2_r[`ASC_C2_RIE] & rx_full_r) |
                         (c2_r[`ASC_C2_IDLE_IRQ_EN] & idle_r));
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence off_seq;
        !on ##1 !on;
    endsequence

    out_own_a: assert property (on |=> serial_out_oe_o)
        else $error("tx pin not driven while enabled");
    in_own_a: assert property (on |=> !serial_in_oe_o)
        else $error("rx pin driven while enabled");
    off_flags_a: assert property (off_seq |-> tx_empty_r && tx_done_r
                                  && !tx_irq_o)
        else $error("disable did not force tx flags");
    tx_invert_a: assert property (on |=> serial_out_pin_o ==
                                  ($past(tx_line) ^ $past(c1_r[`ASC_C1_INV])))
        else $error("tx level polarity wrong");
    frame_len_a: assert property (tx_load && ld_dat |=>
                                  tcnt_r == (nine ? 4'hB : 4'hA))
        else $error("frame length wrong");
    pre_pend_a: assert property (on && wr_c2 && hwdata_i[3] && !c2_r[3]
                                 |=> pre_r)
        else $error("preamble not queued");
    stby_irq_a: assert property (c2_r[`ASC_C2_STBY] |=> !rx_irq_o)
        else $error("rx request during standby");
    brk_zero_a: assert property (tx_load && ld_brk |=> !tx_line)
        else $error("break not sent");
    ctrl_rst_a: assert property (disable iff (1'b0)
                                 !nrst_i |=> c1_r == 8'h00 && c2_r == 8'h00)
        else $error("control not cleared by reset");
    rx_keep_a: assert property (!ren && !rd_dat && rx_full_r |=> rx_full_r)
        else $error("receiver flag lost on disable");
endmodule : asc_ctrl

// [asc_line_partner.sv]
// Remote serial transceiver that faces the block's transmit and receive pins.
// Assumes the baud divider is 0, so one bit lasts 16 module clocks.
module asc_line_partner #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_i,  // Module clock
    input  wire logic line_i, // Level from the block
    output logic      line_o  // Level to the block
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] got;   // Last frame captured, start in bit 0
    int          n_got; // Frames captured so far
    // Idle line rests high
    initial begin
        line_o = 1'b1;
    end
    // Send n bits LSB first, start bit already in bit 0
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask : send
    // Capture eleven bits after each falling edge, near mid-bit
    initial begin
        n_got = 0;
        forever begin
            @(negedge line_i);
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 11; i++) begin
                got[i] = line_i;
                repeat (BIT_CLKS) @(posedge clk_i);
            end
            n_got++;
        end
    end
endmodule : asc_line_partner

// [async_serial_ctrl_regs_tb_top.sv]
// Self-checking bench: registers over AHB-Lite, serial frames via a line partner.
// Assumes the design's register map at offsets 0x00 to 0x14.
module async_serial_ctrl_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, nrst_i, hsel, hwrite, hrdy, hresp;
    logic        in_dir, out_dir, pout, tx_pin, rx_pin;
    logic        oe_out, oe_in, tx_irq, rx_irq, t9, any1;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  lfsr_r, b;
    logic [10:0] f;
    int          fail_count, n_compared, n0;

    asc_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .serial_in_pin_i(rx_pin), .in_pin_dir_bit_i(in_dir),
        .out_pin_dir_bit_i(out_dir), .port_out_i(pout), .serial_out_pin_o(tx_pin),
        .serial_out_oe_o(oe_out), .serial_in_oe_o(oe_in), .tx_irq_o(tx_irq),
        .rx_irq_o(rx_irq));
    asc_line_partner i_far (.clk_i(clk_i), .line_i(tx_pin), .line_o(rx_pin));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [7:0] lfsr_nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_nxt
    // Expected frame; m[0] nine bits, m[1] parity on, m[2] odd
    function automatic logic [10:0] frm(input logic [7:0] v, input logic n9,
                                        input logic [2:0] m);
        logic [8:0] d;
        d = {n9 & m[0], v};
        if (m[1] && m[0]) d[8] = ^d[7:0] ^ m[2];
        if (m[1] && !m[0]) d[7] = ^d[6:0] ^ m[2];
        frm = {2'b11, d, 1'b0};
        if (!m[0]) frm[9] = 1'b1;
    endfunction : frm
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: value %h, expected %h", $time, g, e);
        end
    endtask : chk32
    task automatic chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: pin %b, expected %b", $time, g, e);
        end
    endtask : chk1
    // One single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        chk32(x, e);
    endtask : rdc
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // Watchdog against a hung handshake or frame
    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {fail_count, n_compared, nrst_i, hsel, hwrite, in_dir, out_dir, pout} = '0;
        {htrans, haddr, hwdata} = '0;
        lfsr_r = 8'h39;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(8'h00, 32'h00);
        rdc(8'h04, 32'h00);
        rdc(8'h0C, 32'hC0);
        rdc(8'h14, 32'h0F);
        rdc(8'h18, 32'h00);
        out_dir <= 1'b1;
        in_dir <= 1'b1;
        wr(8'h04, 32'h0C);
        rdc(8'h04, 32'h00);
        chk1(oe_in, 1'b1);
        out_dir <= 1'b0;
        wr(8'h00, 32'h40);
        repeat (3) @(posedge clk_i);
        chk1(oe_out, 1'b1);
        chk1(oe_in, 1'b0);
        wr(8'h00, 32'h60);
        repeat (3) @(posedge clk_i);
        chk1(tx_pin, 1'b0);
        wr(8'h04, 32'h80);
        repeat (3) @(posedge clk_i);
        chk1(tx_irq, 1'b1);
        wr(8'h00, 32'h00);
        repeat (3) @(posedge clk_i);
        chk1(tx_irq, 1'b0);
        wr(8'h00, 32'h40);
        wr(8'h14, 32'h00);
        wr(8'h04, 32'h0C);
        // Let the preamble and any capture started by earlier pin glitches finish
        repeat (400) @(posedge clk_i);
        // Every length and parity mode, both directions
        for (int m = 0; m < 8; m++) begin
            lfsr_r = lfsr_nxt(lfsr_r);
            b = lfsr_r;
            lfsr_r = lfsr_nxt(lfsr_r);
            t9 = lfsr_r[0];
            f = frm(b, t9, m[2:0]);
            wr(8'h00, {24'h0, 3'b010, m[0], 2'b00, m[1], m[2]});
            wr(8'h08, {24'h0, 1'b0, t9, 6'h0});
            n0 = i_far.n_got;
            wr(8'h10, {24'h0, b});
            for (int k = 0; k < 800 && i_far.n_got == n0; k++) @(posedge clk_i);
            chk32({21'h0, i_far.got}, {21'h0, f});
            i_far.send(f, m[0] ? 11 : 10);
            repeat (4) @(posedge clk_i);
            // Idle gap after the previous delivered frame raises the idle flag
            rdc(8'h0C, (m == 0) ? 32'hE0 : 32'hF0);
            rdc(8'h10, {24'h0, f[8:1]});
            rdc(8'h08, {24'h0, m[0] ? f[9] : f[8], t9, 6'h0});
        end
        // Standby with address-mark wakeup
        wr(8'h00, 32'h48);
        wr(8'h04, 32'h2E);
        i_far.send(frm(8'h35, 1'b0, 3'h0), 10);
        repeat (4) @(posedge clk_i);
        chk1(rx_irq, 1'b0);
        rdc(8'h04, 32'h2E);
        i_far.send(frm(8'hA5, 1'b0, 3'h0), 10);
        repeat (4) @(posedge clk_i);
        rdc(8'h04, 32'h2C);
        chk1(rx_irq, 1'b1);
        rdc(8'h0C, 32'hE0);
        rdc(8'h10, 32'hA5);
        // Loopback carries the transmitter into the receiver
        wr(8'h00, 32'hC0);
        wr(8'h04, 32'h0C);
        wr(8'h10, 32'h5A);
        repeat (400) @(posedge clk_i);
        rdc(8'h10, 32'h5A);
        // Held break: no ones between break characters
        wr(8'h00, 32'h40);
        wr(8'h04, 32'h0D);
        repeat (40) @(posedge clk_i);
        any1 = 1'b0;
        for (int k = 0; k < 20; k++) begin
            repeat (16) @(posedge clk_i);
            any1 = any1 | tx_pin;
        end
        chk1(any1, 1'b0);
        wr(8'h04, 32'h0C);
        for (int k = 0; k < 400 && tx_pin !== 1'b1; k++) @(posedge clk_i);
        chk1(tx_pin, 1'b1);
        print_verdict();
    end
endmodule : async_serial_ctrl_regs_tb_top
